//--- common/ddio_pkg.sv
package ddio_pkg;

  // ---------------------------------------------------------------
  // Clock and timing
  // ---------------------------------------------------------------
  localparam int CLK_MHZ = 200;
  localparam int SLOW_RESP_US = 1000;
  localparam int FAST_RESP_US = 100;
  // Input filter windows, kept well inside the response limits
  localparam int SLOW_FILT_US = 500;
  localparam int FAST_FILT_US = 50;
  localparam int SLOW_FILT_CYC = SLOW_FILT_US * CLK_MHZ;
  localparam int FAST_FILT_CYC = FAST_FILT_US * CLK_MHZ;
  localparam int FILT_W = 17;

  // ---------------------------------------------------------------
  // Register offsets (byte addresses)
  // ---------------------------------------------------------------
  localparam logic [7:0] ADR_CTRL = 8'h00;
  localparam logic [7:0] ADR_STAT = 8'h04;
  localparam logic [7:0] ADR_STEP = 8'h08;
  localparam logic [7:0] ADR_FAULT_SET = 8'h0c;
  localparam logic [7:0] ADR_IRQ_STAT = 8'h10;
  localparam logic [7:0] ADR_IRQ_CLR = 8'h14;
  localparam logic [7:0] ADR_IRQ_EN = 8'h18;

  // ---------------------------------------------------------------
  // Control register fields
  // ---------------------------------------------------------------
  localparam int CTL_EN_POL = 0;
  localparam int CTL_CW_POL = 1;
  localparam int CTL_CCW_POL = 2;
  localparam int CTL_DIR_POL = 3;
  localparam int CTL_CW_ON = 4;
  localparam int CTL_CCW_ON = 5;
  localparam int CTL_SW_EN = 6;
  localparam int CTL_NET_EN = 7;
  localparam int CTL_POS_MODE = 8;
  localparam int CTL_SRC_LO = 9;
  localparam int CTL_SRC_HI = 10;
  localparam int CTL_W = 11;
  localparam logic [10:0] CTL_RESET = 11'h070;

  // Position command source
  localparam logic [1:0] SRC_ANALOG = 2'h0;
  localparam logic [1:0] SRC_STEP_DIR = 2'h1;
  localparam logic [1:0] SRC_PWM = 2'h2;

  // ---------------------------------------------------------------
  // Status register fields
  // ---------------------------------------------------------------
  localparam int ST_EN_IN = 0;
  localparam int ST_CW_IN = 1;
  localparam int ST_CCW_IN = 2;
  localparam int ST_DIR_IN = 3;
  localparam int ST_FAST_IN = 4;
  localparam int ST_FAULT = 5;
  localparam int ST_RUN = 6;
  localparam int ST_CW_BLK = 7;
  localparam int ST_CCW_BLK = 8;

  // Event bits
  localparam int EV_W = 4;
  localparam int EV_FAULT = 0;
  localparam int EV_FAULT_CLR = 1;
  localparam int EV_CW_LIM = 2;
  localparam int EV_CCW_LIM = 3;

  typedef struct packed {
    logic [FILT_W-1:0] cnt;
    logic sync0;
    logic sync1;
    logic level;
  } ddio_filt_t;

  typedef struct packed {
    logic fast_s0;
    logic fast_s1;
    logic fast_d;
    ddio_filt_t en_f;
    ddio_filt_t cw_f;
    ddio_filt_t ccw_f;
    ddio_filt_t dir_f;
    logic [CTL_W-1:0] ctrl;
    logic fault;
    logic run;
    logic [31:0] steps;
    logic [EV_W-1:0] irq_stat;
    logic [EV_W-1:0] irq_en;
    logic ack;
    logic [31:0] dat;
    logic cw_blk_d;
    logic ccw_blk_d;
  } ddio_state_t;

endpackage

//--- core/ddio_core.sv
// Our own choices: the address map and register access over Wishbone.
`timescale 1ns/1ps
module ddio_core
  import ddio_pkg::*;
#(
  parameter bit NET_OPTION = 1'b0,
  parameter int SLOW_CYC = SLOW_FILT_CYC,
  parameter int FAST_CYC = FAST_FILT_CYC
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic enable_input_i,
  input wire logic cw_limit_input_i,
  input wire logic ccw_limit_input_i,
  input wire logic direction_input_i,
  input wire logic fast_pulse_input_i,
  input wire logic powered_i,
  input wire logic fault_event_i,
  input wire logic option_cw_limit_i,
  input wire logic option_ccw_limit_i,
  input wire logic [31:0] wb_adr_i,
  input wire logic [31:0] wb_dat_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic wb_we_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  output logic wb_err_o,
  output logic fault_status_output_o,
  output logic run_status_output_o,
  output logic drive_enable_o,
  output logic cw_blocked_o,
  output logic ccw_blocked_o,
  output logic pwm_input_o,
  output logic step_pulse_o,
  output logic step_dir_o,
  output logic irq_o
);

  // ---------------------------------------------------------------
  // Helpers
  // ---------------------------------------------------------------
  // Two-stage synchroniser followed by a stability filter
  function automatic ddio_filt_t filt_step(ddio_filt_t f, logic raw,
                                           int lim);
    ddio_filt_t n;
    n = f;
    n.sync0 = raw;
    n.sync1 = f.sync0;
    if (f.sync1 == f.level) begin
      n.cnt = '0;
    end else if (int'(f.cnt) >= lim - 1) begin
      n.cnt = '0;
      n.level = f.sync1;
    end else begin
      n.cnt = f.cnt + FILT_W'(1);
    end
    return n;
  endfunction

  function automatic logic [31:0] merge(logic [31:0] old,
                                       logic [31:0] wr, logic [3:0] sel);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++) begin
      if (sel[i]) begin
        r[i*8 +: 8] = wr[i*8 +: 8];
      end
    end
    return r;
  endfunction

  ddio_state_t q;
  ddio_state_t next_q;

  logic en_act;
  logic cw_act;
  logic ccw_act;
  logic dir_act;
  logic step_mode;
  logic pwm_mode;
  logic step_edge;
  logic cw_on;
  logic [EV_W-1:0] events;
  logic [31:0] status_word;
  logic req;
  logic mapped;
  logic [31:0] wr_ctl;
  logic [31:0] wr_en;

  // ---------------------------------------------------------------
  // Input mapping
  // ---------------------------------------------------------------
  // Filtered level is hardware-active; set polarity bit inverts it
  assign en_act = q.en_f.level ^ q.ctrl[CTL_EN_POL];
  assign cw_act = q.cw_f.level ^ q.ctrl[CTL_CW_POL];
  assign ccw_act = q.ccw_f.level ^ q.ctrl[CTL_CCW_POL];
  assign dir_act = q.dir_f.level ^ q.ctrl[CTL_DIR_POL];
  assign cw_on = q.ctrl[CTL_CW_ON] & ~NET_OPTION;

  assign pwm_mode = q.ctrl[CTL_SRC_HI:CTL_SRC_LO] == SRC_PWM;
  assign step_mode = q.ctrl[CTL_POS_MODE] &
                     (q.ctrl[CTL_SRC_HI:CTL_SRC_LO] == SRC_STEP_DIR);
  // Falling edge of diode current on the synchronised fast input
  assign step_edge = step_mode & q.fast_d & ~q.fast_s1;

  assign events[EV_FAULT] = fault_event_i & ~q.fault;
  assign events[EV_FAULT_CLR] = q.fault & ~en_act;
  assign events[EV_CW_LIM] = cw_blocked_o & ~q.cw_blk_d;
  assign events[EV_CCW_LIM] = ccw_blocked_o & ~q.ccw_blk_d;

  assign req = wb_cyc_i & wb_stb_i & ~q.ack;
  assign mapped = wb_adr_i[7:0] <= ADR_IRQ_EN && wb_adr_i[1:0] == 2'h0 &&
                  wb_adr_i[31:8] == 24'h0;
  assign wr_ctl = merge(32'(q.ctrl), wb_dat_i, wb_sel_i);
  assign wr_en = merge(32'(q.irq_en), wb_dat_i, wb_sel_i);

  always_comb begin
    status_word = '0;
    status_word[ST_EN_IN] = q.en_f.level;
    status_word[ST_CW_IN] = q.cw_f.level;
    status_word[ST_CCW_IN] = q.ccw_f.level;
    status_word[ST_DIR_IN] = q.dir_f.level;
    status_word[ST_FAST_IN] = q.fast_s1;
    status_word[ST_FAULT] = q.fault;
    status_word[ST_RUN] = q.run;
    status_word[ST_CW_BLK] = cw_blocked_o;
    status_word[ST_CCW_BLK] = ccw_blocked_o;
  end

  // ---------------------------------------------------------------
  // Next state
  // ---------------------------------------------------------------
  always_comb begin
    next_q = q;
    next_q.fast_s0 = fast_pulse_input_i;
    next_q.fast_s1 = q.fast_s0;
    next_q.fast_d = q.fast_s1;
    next_q.en_f = filt_step(q.en_f, enable_input_i, SLOW_CYC);
    next_q.cw_f = filt_step(q.cw_f, cw_limit_input_i, SLOW_CYC);
    next_q.ccw_f = filt_step(q.ccw_f, ccw_limit_input_i, SLOW_CYC);
    next_q.dir_f = filt_step(q.dir_f, direction_input_i, FAST_CYC);
    next_q.cw_blk_d = cw_blocked_o;
    next_q.ccw_blk_d = ccw_blocked_o;

    // Fault latch; inactive enable clears, a new fault wins
    if (fault_event_i) begin
      next_q.fault = 1'b1;
    end else if (!en_act) begin
      next_q.fault = 1'b0;
    end

    // Enable gate: input first, then fault, power and soft enables
    next_q.run = en_act & ~next_q.fault & powered_i &
                 q.ctrl[CTL_SW_EN] & q.ctrl[CTL_NET_EN];

    // Step counter; direction inactive counts up
    if (step_edge) begin
      if (!dir_act) begin
        next_q.steps = q.steps + 32'h1;
      end else begin
        next_q.steps = q.steps - 32'h1;
      end
    end

    // Bus slave
    next_q.ack = req;
    next_q.dat = '0;
    next_q.irq_stat = q.irq_stat | events;
    if (req && mapped) begin
      if (wb_we_i) begin
        unique case (wb_adr_i[7:0])
          ADR_CTRL: next_q.ctrl = wr_ctl[CTL_W-1:0];
          ADR_STEP: next_q.steps = merge(q.steps, wb_dat_i, wb_sel_i);
          ADR_FAULT_SET: begin
            if (wb_sel_i[0] && wb_dat_i[0]) begin
              next_q.fault = 1'b1;
              next_q.run = 1'b0;
            end
          end
          ADR_IRQ_CLR: begin
            if (wb_sel_i[0]) begin
              next_q.irq_stat = (q.irq_stat & ~wb_dat_i[EV_W-1:0]) |
                                events;
            end
          end
          ADR_IRQ_EN: next_q.irq_en = wr_en[EV_W-1:0];
          default: begin
          end
        endcase
      end else begin
        unique case (wb_adr_i[7:0])
          ADR_CTRL: next_q.dat = 32'(q.ctrl);
          ADR_STAT: next_q.dat = status_word;
          ADR_STEP: next_q.dat = q.steps;
          ADR_IRQ_STAT: next_q.dat = 32'(q.irq_stat);
          ADR_IRQ_EN: next_q.dat = 32'(q.irq_en);
          default: next_q.dat = '0;
        endcase
      end
    end

    if (rst_i) begin
      next_q = '0;
      next_q.ctrl = CTL_RESET;
    end
  end

  always_ff @(posedge clk_i) begin
    q <= next_q;
  end

  // ---------------------------------------------------------------
  // Outputs
  // ---------------------------------------------------------------
  assign wb_ack_o = q.ack;
  assign wb_err_o = 1'b0;
  assign wb_dat_o = q.dat;
  assign drive_enable_o = q.run;
  assign fault_status_output_o = powered_i & ~q.fault;
  assign run_status_output_o = q.run;
  assign cw_blocked_o = cw_on & cw_act;
  assign ccw_blocked_o = q.ctrl[CTL_CCW_ON] & ccw_act;
  assign pwm_input_o = pwm_mode & q.fast_d;
  assign step_pulse_o = step_edge;
  assign step_dir_o = dir_act;
  assign irq_o = |(q.irq_stat & q.irq_en);

endmodule

//--- dv/ddio_core_sva.sv
`timescale 1ns/1ps
module ddio_chk (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_ack_o,
  input wire logic powered_i,
  input wire logic fault_event_i,
  input wire logic fast_pulse_input_i,
  input wire logic cw_limit_input_i,
  input wire logic fault_status_output_o,
  input wire logic run_status_output_o,
  input wire logic drive_enable_o,
  input wire logic cw_blocked_o,
  input wire logic step_pulse_o,
  input wire logic pwm_input_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  sequence take_s;
    wb_cyc_i && wb_stb_i && !wb_ack_o;
  endsequence
  sequence ans_s;
    wb_ack_o ##1 !wb_ack_o;
  endsequence
  bus_answer_a: assert property (take_s |=> ans_s)
    else $error("bus answer late or long");
  ack_cause_a: assert property (wb_ack_o |-> $past(wb_cyc_i && wb_stb_i))
    else $error("ack without request");
  fault_off_a: assert property (
    fault_event_i |-> ##[1:3] !fault_status_output_o)
    else $error("fault output stays on");
  unpow_off_a: assert property (
    !powered_i |-> !fault_status_output_o) else $error("fault output on");
  run_pow_a: assert property (
    !powered_i |=> !run_status_output_o) else $error("run while unpowered");
  run_fault_a: assert property (
    drive_enable_o |-> $past(fault_status_output_o))
    else $error("enabled while faulted");
  run_same_a: assert property (
    run_status_output_o == drive_enable_o) else $error("run mismatch");
  step_once_a: assert property (
    step_pulse_o |=> !step_pulse_o) else $error("step pulse too long");
  step_fall_a: assert property (
    step_pulse_o |-> !pwm_input_o && !$past(fast_pulse_input_i, 2))
    else $error("step without falling edge");
  cw_sync_a: assert property (
    $rose(cw_limit_input_i) |=> $stable(cw_blocked_o))
    else $error("limit not synchronised");
endmodule

bind ddio_core ddio_chk u_chk (.clk_i, .rst_i, .wb_cyc_i, .wb_stb_i,
  .wb_ack_o, .powered_i, .fault_event_i, .fast_pulse_input_i,
  .cw_limit_input_i, .fault_status_output_o, .run_status_output_o,
  .drive_enable_o, .cw_blocked_o, .step_pulse_o, .pwm_input_o);

//--- dv/ddio_field.sv
`timescale 1ns/1ps
// Switch levels and a step source, period 140 cycles, high 60
module ddio_field (
  input wire logic clk_i,
  input wire logic [3:0] lvl_i,
  input wire logic [7:0] n_i,
  input wire logic go_i,
  output logic [3:0] pin_o,
  output logic fast_o,
  output logic busy_o
);
  logic [7:0] left = 8'h00;
  logic [7:0] ph = 8'h00;
  assign pin_o = lvl_i;
  assign busy_o = left != 8'h00;
  assign fast_o = busy_o && ph < 8'h3c;
  always @(posedge clk_i) begin
    if (go_i && !busy_o) begin
      left <= n_i;
      ph <= 8'h00;
    end else if (busy_o) begin
      ph <= (ph == 8'h8b) ? 8'h00 : ph + 8'h01;
      if (ph == 8'h8b) left <= left - 8'h01;
    end
  end
endmodule

//--- dv/tb_drive_discrete_io_logic.sv
`timescale 1ns/1ps
`define CHK(n, e, g) begin tests_run++; if ((g) !== (e)) begin \
  err_count++; $display("BAD %s exp %h got %h", n, e, g); end end
module tb_drive_discrete_io_logic
  import ddio_pkg::*;
;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic cyc = 1'b0;
  logic we = 1'b0;
  logic pwr = 1'b1;
  logic fev = 1'b0;
  logic go = 1'b0;
  logic [3:0] lvl = 4'h0;
  logic [7:0] nst = 8'h00;
  logic [31:0] adr = 32'h0;
  logic [31:0] wd = 32'h0;
  logic [31:0] rdat, dat;
  logic [3:0] pin;
  logic ack, fst, busy, fok, run, den, cwb, ccwb, pwm, stp, sdir, irq;
  logic [10:0] cv [6] = '{11'h0f0, 11'h0b0, 11'h070, 11'h0f1, 11'h0f1,
    11'h0f0};
  logic [5:0] ev = 6'h11;
  logic [5:0] lv = 6'h0f;
  int err_count = 0;
  int tests_run = 0;
  int nstp = 0;
  int npwm = 0;
  always #2.5 clk_i = ~clk_i;
  always @(posedge clk_i) if (stp === 1'b1) nstp++;
  always @(posedge clk_i) if (pwm === 1'b1) npwm++;
  ddio_field fld (.clk_i, .lvl_i(lvl), .n_i(nst), .go_i(go), .pin_o(pin),
    .fast_o(fst), .busy_o(busy));
  ddio_core #(.SLOW_CYC(8), .FAST_CYC(4)) uut (.clk_i, .rst_i,
    .enable_input_i(pin[0]), .cw_limit_input_i(pin[1]),
    .ccw_limit_input_i(pin[2]), .direction_input_i(pin[3]),
    .fast_pulse_input_i(fst), .powered_i(pwr), .fault_event_i(fev),
    .option_cw_limit_i(1'b0), .option_ccw_limit_i(1'b0),
    .wb_adr_i(adr), .wb_dat_i(wd), .wb_sel_i(4'hf), .wb_we_i(we),
    .wb_cyc_i(cyc), .wb_stb_i(cyc), .wb_dat_o(dat), .wb_ack_o(ack),
    .wb_err_o(), .fault_status_output_o(fok), .run_status_output_o(run),
    .drive_enable_o(den), .cw_blocked_o(cwb), .ccw_blocked_o(ccwb),
    .pwm_input_o(pwm), .step_pulse_o(stp), .step_dir_o(sdir), .irq_o(irq));
  // ------------
  // Bus and waits
  // ------------
  task automatic bus(input logic w, input logic [7:0] a,
    input logic [31:0] d);
    int n;
    n = 0;
    adr <= {24'h000000, a};
    wd <= d;
    we <= w;
    cyc <= 1'b1;
    @(posedge clk_i);
    while (ack !== 1'b1 && n < 20) begin
      @(posedge clk_i);
      n++;
    end
    if (n == 20) err_count++;
    rdat = dat;
    cyc <= 1'b0;
    @(posedge clk_i);
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge clk_i);
  endtask
  task automatic burst(input logic [7:0] k);
    nst <= k;
    go <= 1'b1;
    tick(1);
    go <= 1'b0;
    tick(1);
    while (busy) @(posedge clk_i);
    tick(10);
  endtask
  task automatic results();
    $display("tests %0d errors %0d", tests_run, err_count);
    if (err_count == 0 && tests_run > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  initial begin
    #200000;
    err_count++;
    results();
  end
  // ------------
  // Tests
  // ------------
  initial begin
    tick(6);
    rst_i <= 1'b0;
    tick(1);
    bus(1'b0, ADR_CTRL, 32'h0);
    `CHK("ctrl", {21'h0, CTL_RESET}, rdat)
    bus(1'b1, 8'h1c, 32'hffffffff);
    bus(1'b0, 8'h1c, 32'h0);
    `CHK("unmapped", 32'h0, rdat)
    `CHK("fok", 1'b1, fok)
    $display("test reset done");
    for (int i = 0; i < 6; i++) begin
      lvl <= {3'h0, lv[i]};
      bus(1'b1, ADR_CTRL, {21'h0, cv[i]});
      tick(20);
      `CHK("run", ev[i], run)
    end
    $display("test enable done");
    bus(1'b1, ADR_IRQ_CLR, 32'hf);
    bus(1'b1, ADR_IRQ_EN, 32'hf);
    lvl <= 4'h1;
    tick(20);
    fev <= 1'b1;
    tick(1);
    fev <= 1'b0;
    tick(3);
    `CHK("fok", 1'b0, fok)
    `CHK("run", 1'b0, run)
    `CHK("irq", 1'b1, irq)
    bus(1'b1, ADR_IRQ_CLR, 32'h1);
    `CHK("irq", 1'b0, irq)
    bus(1'b1, ADR_IRQ_EN, 32'h0);
    lvl <= 4'h0;
    tick(20);
    `CHK("fok", 1'b1, fok)
    `CHK("irq", 1'b0, irq)
    bus(1'b0, ADR_IRQ_STAT, 32'h0);
    `CHK("istat", 32'h2, rdat)
    bus(1'b1, ADR_IRQ_EN, 32'h2);
    `CHK("irq", 1'b1, irq)
    bus(1'b1, ADR_IRQ_CLR, 32'hf);
    `CHK("irq", 1'b0, irq)
    pwr <= 1'b0;
    tick(2);
    `CHK("fok", 1'b0, fok)
    pwr <= 1'b1;
    lvl <= 4'h1;
    tick(20);
    `CHK("run", 1'b1, run)
    bus(1'b1, ADR_FAULT_SET, 32'h1);
    `CHK("fok", 1'b0, fok)
    `CHK("run", 1'b0, run)
    $display("test fault done");
    lvl <= 4'h2;
    tick(20);
    `CHK("cwb", 2'h2, {cwb, ccwb})
    lvl <= 4'h4;
    tick(20);
    `CHK("ccwb", 2'h1, {cwb, ccwb})
    bus(1'b1, ADR_CTRL, 32'h0d0);
    tick(2);
    `CHK("ccwb", 2'h0, {cwb, ccwb})
    $display("test limits done");
    lvl <= 4'h0;
    bus(1'b1, ADR_CTRL, 32'h3f0);
    bus(1'b1, ADR_STEP, 32'h0);
    tick(20);
    `CHK("sdir", 1'b0, sdir)
    burst(8'h05);
    bus(1'b0, ADR_STEP, 32'h0);
    `CHK("steps", 32'h5, rdat)
    lvl <= 4'h8;
    tick(20);
    `CHK("sdir", 1'b1, sdir)
    burst(8'h03);
    bus(1'b0, ADR_STEP, 32'h0);
    `CHK("steps", 32'h2, rdat)
    bus(1'b1, ADR_CTRL, 32'h4f0);
    burst(8'h02);
    `CHK("pulses", 8, nstp)
    `CHK("pwm", 120, npwm)
    $display("test steps done");
    results();
  end
endmodule
